// ---- verif/cell_agc_regs_props.sv ----
// port assertions for the cellular agc register bank
// assumes one clock and rstn; bound to every cell_agc_regs
module cell_agc_regs_props
  import cell_agc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic cell_agc_enable,
  input wire logic [2:0] agc_noise_threshold,
  input wire logic [1:0] cell_hysteresis_sel,
  input wire logic hysteresis_active,
  input wire logic [1:0] attack_sel,
  input wire logic [1:0] decay_sel,
  input wire logic decay_short,
  input wire logic headphone_pop_reduce_en,
  input wire logic buzzer_input_route_en,
  input wire logic pop_seq_active,
  input wire logic pop_seq_done
);
  logic we;
  assign we = wr & clk_en;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // a frozen clock enable keeps old read data, so only running cycles count
  AST_RD_IDLE: assert property ($past(clk_en) && !$past(rd) |-> rdata == 16'h0)
    else $error("rdata not zero between reads");
  AST_AGC_RSV: assert property ($past(rd && clk_en && addr == OFF_AGC_CTRL) |-> !rdata[15])
    else $error("agc reserved bit set");
  AST_DRV_RSV: assert property ($past(rd && clk_en && addr == OFF_DRV_STAT) |-> rdata[3:0] == 4'h0)
    else $error("driver reserved bits set");
  AST_AGC_WR: assert property (we && addr == OFF_AGC_CTRL |=> cell_agc_enable == $past(wdata[0])
    && agc_noise_threshold == $past(wdata[13:11])) else $error("agc write not applied");
  AST_HYS: assert property (hysteresis_active == (cell_hysteresis_sel != HYS_OFF))
    else $error("hysteresis decode wrong");
  AST_DECAY: assert property (decay_short == ({decay_sel, attack_sel} == 4'h0))
    else $error("short decay decode wrong");
  AST_DRV_WR: assert property (we && addr == OFF_DRV_STAT |=> buzzer_input_route_en ==
    !$past(wdata[8]) && headphone_pop_reduce_en == $past(wdata[9])) else $error("driver write wrong");
  AST_DONE: assert property (pop_seq_done && $past(clk_en) |->
    $past(pop_seq_active) && !pop_seq_active) else $error("done without active sequence");
  AST_DONE_PULSE: assert property (pop_seq_done && clk_en |=> !pop_seq_done)
    else $error("done longer than one cycle");
endmodule

bind cell_agc_regs cell_agc_regs_props i_props (.*);

// ---- verif/test_cell_agc_regs.sv ----
// self-checking bench for the cellular agc register bank
// assumes a shortened millisecond tick so pop sequences stay brief
module test_cell_agc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import cell_agc_pkg::*;
  localparam int unsigned TK = 4;
  logic clock, rstn, clk_en, wr, rd, irq, below_noise_in, seq_start, cell_agc_enable;
  logic hysteresis_active, cell_clip_step_en, decay_short, agc_tick, headphone_pop_reduce_en;
  logic buzzer_input_route_en, speaker_two_to_buzzer_en, speaker_one_to_buzzer_en;
  logic pop_seq_active, pop_seq_done;
  logic rd_seen = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [5:0] driver_down_in;
  logic [2:0] agc_noise_threshold, cell_target_level;
  logic [1:0] cell_hysteresis_sel, attack_sel, decay_sel;
  logic [15:0] exp_q[$];
  int err_total, checked, seed, n, m;
  cell_agc_regs #(.TICK_CYCLES(TK)) i_dut (.*);
  task automatic complete_run();
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(v);
    @(posedge clock);
    rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= rd && clk_en;
  end
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200us;
    err_total++;
    complete_run();
  end
  initial begin
    seed = 99736;
    {rstn, wr, rd, seq_start, below_noise_in} = 5'h0;
    clk_en = 1'b1;
    addr = '0;
    wdata = '0;
    driver_down_in = 6'h3f;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(OFF_AGC_CTRL, AGC_RESET);
    // no short-circuit input here, so the flags are always trusted
    rd_reg(OFF_DRV_STAT, 16'hfc00);
    rd_reg(6'h3f, 16'h0);
    repeat (4) begin
      d = $random(seed);
      // codes above four are not for the cellular path
      if (d[13:11] > 3'h4) d[13:11] = 3'h4;
      d[15:14] = 2'h0;
      driver_down_in <= d[5:0];
      wr_reg(OFF_AGC_CTRL, d);
      @(negedge clock);
      chk({2'h0, agc_noise_threshold, cell_hysteresis_sel, cell_clip_step_en, cell_target_level,
        decay_sel, attack_sel, cell_agc_enable}, {2'h0, d[13:0]});
      rd_reg(OFF_AGC_CTRL, d & AGC_WMASK);
      wr_reg(OFF_DRV_STAT, {6'h0, d[9:4], 4'h0});
      @(negedge clock);
      chk({headphone_pop_reduce_en, buzzer_input_route_en, speaker_two_to_buzzer_en,
        speaker_one_to_buzzer_en}, {d[9], !d[8], d[7:6]});
      rd_reg(OFF_DRV_STAT, {d[5:0], d[9:4], 4'h0});
    end
    below_noise_in <= 1'b1;
    wr_reg(OFF_AGC_CTRL, 16'h0001);
    rd_reg(OFF_AGC_CTRL, 16'h4001);
    clk_en <= 1'b0;
    wr_reg(OFF_AGC_CTRL, 16'h0000);
    clk_en <= 1'b1;
    rd_reg(OFF_AGC_CTRL, 16'h4001);
    wr_reg(OFF_DRV_STAT, 16'h0000);
    wr_reg(OFF_IRQ_MASK, 16'h0002);
    wr_reg(OFF_IRQ_STATUS, 16'h0007);
    rd_reg(OFF_IRQ_STATUS, 16'h0000);
    @(negedge clock);
    chk(irq, 1'b0);
    seq_start <= 1'b1;
    @(posedge clock);
    seq_start <= 1'b0;
    n = 0;
    m = 0;
    while (pop_seq_done !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
      if (agc_tick) m++;
    end
    chk(n >= 801 * TK && n <= 803 * TK + 2, 1'b1);
    chk(m >= 801 && m <= 803, 1'b1);
    @(negedge clock);
    chk(irq, 1'b1);
    wr_reg(OFF_IRQ_MASK, 16'h0000);
    @(negedge clock);
    chk(irq, 1'b0);
    rd_reg(OFF_IRQ_STATUS, 16'h0002);
    wr_reg(OFF_IRQ_STATUS, 16'h0002);
    rd_reg(OFF_IRQ_STATUS, 16'h0000);
    wr_reg(OFF_DRV_STAT, 16'h0020);
    seq_start <= 1'b1;
    @(posedge clock);
    seq_start <= 1'b0;
    repeat (3) @(negedge clock);
    chk(pop_seq_active, 1'b0);
    repeat (3) @(posedge clock);
    complete_run();
  end
endmodule

// ---- verilog/cell_agc_pkg.sv ----
// constants for the cellular agc and driver status register bank
// assumes a single 200 mhz clock and a plain strobe register port
package cell_agc_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_AGC_CTRL = 6'h24;
  localparam logic [5:0] OFF_DRV_STAT = 6'h25;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h30;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h31;
  // field positions, agc control register
  localparam int unsigned B_NOISE_FLAG = 14;
  localparam int unsigned B_NL_HI = 13;
  localparam int unsigned B_NL_LO = 11;
  localparam int unsigned B_HYS_HI = 10;
  localparam int unsigned B_HYS_LO = 9;
  localparam int unsigned B_CLIP = 8;
  localparam int unsigned B_TG_HI = 7;
  localparam int unsigned B_TG_LO = 5;
  localparam int unsigned B_TC_HI = 4;
  localparam int unsigned B_TC_LO = 1;
  localparam int unsigned B_AGC_EN = 0;
  // field positions, driver status register
  localparam int unsigned B_DRV_HI = 15;
  localparam int unsigned B_DRV_LO = 10;
  localparam int unsigned B_POP_RED = 9;
  localparam int unsigned B_BUZ_DIS = 8;
  localparam int unsigned B_SP2_BUZ = 7;
  localparam int unsigned B_SP1_BUZ = 6;
  localparam int unsigned B_SEQ_DIS = 5;
  localparam int unsigned B_SEQ_DUR = 4;
  localparam logic [15:0] AGC_RESET = 16'h0000;
  localparam logic [15:0] AGC_WMASK = 16'h3fff;
  localparam logic [5:0] DRV_DOWN_RESET = 6'h3f;
  localparam logic [5:0] DRV_CTRL_RESET = 6'h00;
  // interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned I_NOISE = 0;
  localparam int unsigned I_SEQ_DONE = 1;
  localparam int unsigned I_DRV_CHG = 2;
  // timebase: one tick per millisecond
  localparam longint unsigned CLK_HZ = 200000000;
  localparam longint unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = int'(CLK_HZ * TICK_MS / 1000);
  localparam int unsigned SEQ_SHORT_MS = 802;
  localparam int unsigned SEQ_LONG_MS = 4006;
  localparam logic [1:0] HYS_OFF = 2'h3;
  localparam logic [2:0] NL_MAX_CELL = 3'h4;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_t;
endpackage

// ---- verilog/cell_agc_regs.sv ----
// cellular agc control and driver power-down status register bank
// assumes analog side supplies synchronous-unsafe status levels and a
// pop sequence request; only the status levels are resynchronised here
// Summary of operation
// - noise flag bit 14, read only, live
// - shared 3-bit noise threshold field, bits 13-11
// - hysteresis select bits 10-9, 3 is off
// - clip stepping enable bit 8, reset 0
// - target level select bits 7-5
// - time constant bits 4-1: attack, decay
// - time constants fixed in absolute time
// - bit 0 hands cellular pga to agc
// - reserved bits read zero, write ignored
// - six driver down flags, reset to one
// - headphone pop reduction enable bit 9
// - buzzer input route cut when bit 8 set
// - speaker routes to buzzer amp bits 7,6
// - pop sequencing skipped when bit 5 set
// - sequence lasts 802 or 4006 ms
module cell_agc_regs
  import cell_agc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic irq,
  input wire logic below_noise_in,
  input wire logic [5:0] driver_down_in,
  input wire logic seq_start,
  output logic cell_agc_enable,
  output logic [2:0] agc_noise_threshold,
  output logic [1:0] cell_hysteresis_sel,
  output logic hysteresis_active,
  output logic cell_clip_step_en,
  output logic [2:0] cell_target_level,
  output logic [1:0] attack_sel,
  output logic [1:0] decay_sel,
  output logic decay_short,
  output logic agc_tick,
  output logic headphone_pop_reduce_en,
  output logic buzzer_input_route_en,
  output logic speaker_two_to_buzzer_en,
  output logic speaker_one_to_buzzer_en,
  output logic pop_seq_active,
  output logic pop_seq_done
);
  logic [15:0] agc_reg;
  logic [5:0] drv_ctrl;
  logic noise_s1, noise_s2;
  logic [5:0] drv_s1, drv_s2, drv_prev;
  logic noise_prev;
  logic [IRQ_W-1:0] irq_status, irq_mask, irq_event;
  logic [31:0] tick_cnt;
  logic tick;
  logic [12:0] ms_cnt;
  logic [12:0] seq_target;
  seq_state_t seq_state;
  logic wr_agc, wr_drv, wr_stat, wr_mask;

  assign wr_agc = clk_en && wr && addr == OFF_AGC_CTRL;
  assign wr_drv = clk_en && wr && addr == OFF_DRV_STAT;
  assign wr_stat = clk_en && wr && addr == OFF_IRQ_STATUS;
  assign wr_mask = clk_en && wr && addr == OFF_IRQ_MASK;

  // status pins come from the analog domain, two flops before use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      noise_s1 <= 1'b0;
      noise_s2 <= 1'b0;
      drv_s1 <= DRV_DOWN_RESET;
      drv_s2 <= DRV_DOWN_RESET;
    end else if (clk_en) begin
      noise_s1 <= below_noise_in;
      noise_s2 <= noise_s1;
      drv_s1 <= driver_down_in;
      drv_s2 <= drv_s1;
    end
  end

  // control fields; bits 15 and 14 never stored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      agc_reg <= AGC_RESET;
    end else if (wr_agc) begin
      agc_reg <= wdata & AGC_WMASK;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      drv_ctrl <= DRV_CTRL_RESET;
    end else if (wr_drv) begin
      drv_ctrl <= wdata[B_POP_RED:B_SEQ_DUR];
    end
  end

  assign agc_noise_threshold = agc_reg[B_NL_HI:B_NL_LO];
  assign cell_hysteresis_sel = agc_reg[B_HYS_HI:B_HYS_LO];
  assign hysteresis_active = cell_hysteresis_sel != HYS_OFF;
  assign cell_clip_step_en = agc_reg[B_CLIP];
  assign cell_target_level = agc_reg[B_TG_HI:B_TG_LO];
  // low pair is attack, high pair decay; all four bits zero means the short decay
  assign attack_sel = agc_reg[B_TC_LO+1:B_TC_LO];
  assign decay_sel = agc_reg[B_TC_HI:B_TC_HI-1];
  assign decay_short = agc_reg[B_TC_HI:B_TC_LO] == 4'h0;
  assign cell_agc_enable = agc_reg[B_AGC_EN];
  assign headphone_pop_reduce_en = drv_ctrl[B_POP_RED-B_SEQ_DUR];
  assign buzzer_input_route_en = !drv_ctrl[B_BUZ_DIS-B_SEQ_DUR];
  assign speaker_two_to_buzzer_en = drv_ctrl[B_SP2_BUZ-B_SEQ_DUR];
  assign speaker_one_to_buzzer_en = drv_ctrl[B_SP1_BUZ-B_SEQ_DUR];

  // millisecond tick from the system clock, not from the sample rate
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= tick_cnt == TICK_CYCLES - 1;
      if (tick_cnt == TICK_CYCLES - 1) begin
        tick_cnt <= 32'h0000_0000;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end
  assign agc_tick = tick;

  // duration latched at start so a later write cannot stretch a run
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seq_state <= SEQ_IDLE;
      ms_cnt <= 13'h0000;
      seq_target <= 13'h0000;
    end else if (clk_en) begin
      case (seq_state)
        SEQ_IDLE: begin
          if (seq_start && !drv_ctrl[B_SEQ_DIS-B_SEQ_DUR]) begin
            seq_state <= SEQ_RUN;
            ms_cnt <= 13'h0000;
            seq_target <= drv_ctrl[B_SEQ_DUR-B_SEQ_DUR] ? 13'(SEQ_LONG_MS) : 13'(SEQ_SHORT_MS);
          end
        end
        SEQ_RUN: begin
          if (tick) begin
            if (ms_cnt == seq_target - 13'h0001) begin
              seq_state <= SEQ_DONE;
            end
            ms_cnt <= ms_cnt + 13'h0001;
          end
        end
        SEQ_DONE: begin
          seq_state <= SEQ_IDLE;
        end
        default: begin
          seq_state <= SEQ_IDLE;
        end
      endcase
    end
  end
  assign pop_seq_active = seq_state == SEQ_RUN;
  assign pop_seq_done = seq_state == SEQ_DONE;

  // interrupt events: noise entry while agc enabled, sequence end, any driver change
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      noise_prev <= 1'b0;
      drv_prev <= DRV_DOWN_RESET;
    end else if (clk_en) begin
      noise_prev <= noise_s2;
      drv_prev <= drv_s2;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[I_NOISE] = noise_s2 && !noise_prev && cell_agc_enable;
    irq_event[I_SEQ_DONE] = seq_state == SEQ_DONE;
    irq_event[I_DRV_CHG] = drv_s2 != drv_prev;
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~(wr_stat ? wdata[IRQ_W-1:0] : '0)) | irq_event;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read data valid the cycle after the strobe only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      rdata <= 16'h0000;
      if (rd) begin
        case (addr)
          OFF_AGC_CTRL: begin
            rdata <= agc_reg;
            rdata[B_NOISE_FLAG] <= noise_s2;
          end
          OFF_DRV_STAT: begin
            rdata[B_DRV_HI:B_DRV_LO] <= drv_s2;
            rdata[B_POP_RED:B_SEQ_DUR] <= drv_ctrl;
          end
          OFF_IRQ_STATUS: begin
            rdata[IRQ_W-1:0] <= irq_status;
          end
          OFF_IRQ_MASK: begin
            rdata[IRQ_W-1:0] <= irq_mask;
          end
          default: begin
            rdata <= 16'h0000;
          end
        endcase
      end
    end
  end
endmodule
